/* sbsl_pkg.sv */
// package of command codes, bank states and timing counts for bank state logic
package sbsl_pkg;
  // ************************************************************
  // command decode
  // ************************************************************
  typedef enum logic [3:0] {
    SBSL_CMD_DESELECT = 4'h0,
    SBSL_CMD_NOP = 4'h1,
    SBSL_CMD_ACTIVATE = 4'h2,
    SBSL_CMD_READ = 4'h3,
    SBSL_CMD_WRITE = 4'h4,
    SBSL_CMD_PRECHARGE = 4'h5,
    SBSL_CMD_BURST_TERM = 4'h6,
    SBSL_CMD_REFRESH = 4'h7,
    SBSL_CMD_LOAD_MODE = 4'h8
  } sbsl_cmd_e;

  // ************************************************************
  // bank states, gray coded along idle-activating-active-read
  // ************************************************************
  typedef enum logic [2:0] {
    SBSL_ST_IDLE = 3'h0,
    SBSL_ST_ACTIVATING = 3'h1,
    SBSL_ST_ROW_ACTIVE = 3'h3,
    SBSL_ST_READ = 3'h2,
    SBSL_ST_WRITE = 3'h6,
    SBSL_ST_READ_AP = 3'h7,
    SBSL_ST_WRITE_AP = 3'h5,
    SBSL_ST_PRECHARGING = 3'h4
  } sbsl_state_e;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int PRECHARGE_TIME_NS = 15;
  localparam int ACTIVATE_TO_ACCESS_TIME_NS = 15;
  localparam int REFRESH_CYCLE_TIME_NS = 72;
  localparam int MODE_LOAD_TIME_NS = 10;
  localparam int BURST_LEN = 4;
  localparam int BURST_CYCLES = BURST_LEN / 2;
  // least times round up, at least one cycle
  localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACTIVATE_CYC = (ACTIVATE_TO_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_LOAD_CYC = (MODE_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
endpackage : sbsl_pkg

/* sbsl_bank.sv */
// one bank: state register and timing counter
`timescale 1ns/1ps
module sbsl_bank #(
  parameter int CNT_W = sbsl_pkg::CNT_W,
  parameter logic [7:0] ACT_CYC = 8'(sbsl_pkg::ACTIVATE_CYC),
  parameter logic [7:0] PRE_CYC = 8'(sbsl_pkg::PRECHARGE_CYC),
  parameter logic [7:0] BURST_CYC = 8'(sbsl_pkg::BURST_CYCLES)
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // commands addressed to this bank
  input wire logic act_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic pre_i,
  input wire logic auto_pre_i,
  input wire logic burst_stop_i,
  input wire logic force_idle_i,
  // state
  output sbsl_pkg::sbsl_state_e state_o,
  output logic [CNT_W-1:0] count_o
);
  sbsl_pkg::sbsl_state_e state;
  logic [CNT_W-1:0] count;
  logic ap_access; // auto precharge access phase still running
  logic [CNT_W-1:0] cyc_m1;
  assign state_o = state;
  assign count_o = count;

  // state transitions with durations
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= sbsl_pkg::SBSL_ST_IDLE;
      count <= '0;
      ap_access <= 1'b0;
    end else if (force_idle_i) begin
      state <= sbsl_pkg::SBSL_ST_IDLE;
      count <= '0;
      ap_access <= 1'b0;
    end else if (act_i) begin
      state <= sbsl_pkg::SBSL_ST_ACTIVATING;
      count <= CNT_W'(ACT_CYC - 8'h01);
    end else if (pre_i) begin
      state <= sbsl_pkg::SBSL_ST_PRECHARGING;
      count <= CNT_W'(PRE_CYC - 8'h01);
    end else if (rd_i || wr_i) begin
      if (auto_pre_i) begin
        state <= rd_i ? sbsl_pkg::SBSL_ST_READ_AP : sbsl_pkg::SBSL_ST_WRITE_AP;
        ap_access <= 1'b1;
      end else begin
        state <= rd_i ? sbsl_pkg::SBSL_ST_READ : sbsl_pkg::SBSL_ST_WRITE;
      end
      count <= CNT_W'(BURST_CYC - 8'h01);
    end else if (burst_stop_i && state == sbsl_pkg::SBSL_ST_READ) begin
      state <= sbsl_pkg::SBSL_ST_ROW_ACTIVE;
      count <= '0;
    end else if (count != '0) begin
      count <= count - CNT_W'(1);
    end else begin
      case (state)
        sbsl_pkg::SBSL_ST_ACTIVATING: begin
          state <= sbsl_pkg::SBSL_ST_ROW_ACTIVE;
        end
        sbsl_pkg::SBSL_ST_READ, sbsl_pkg::SBSL_ST_WRITE: begin
          state <= sbsl_pkg::SBSL_ST_ROW_ACTIVE;
        end
        sbsl_pkg::SBSL_ST_READ_AP, sbsl_pkg::SBSL_ST_WRITE_AP: begin
          if (ap_access) begin
            ap_access <= 1'b0; // access phase over, precharge phase
            count <= CNT_W'(PRE_CYC - 8'h01);
          end else begin
            state <= sbsl_pkg::SBSL_ST_IDLE;
          end
        end
        sbsl_pkg::SBSL_ST_PRECHARGING: begin
          state <= sbsl_pkg::SBSL_ST_IDLE;
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end
endmodule : sbsl_bank

/* sbsl_top.sv */
// top of bank state logic: command decode, device-wide timers, legality check
`timescale 1ns/1ps
module sbsl_top #(
  parameter int NUM_BANKS = sbsl_pkg::NUM_BANKS,
  parameter int BANK_W = sbsl_pkg::BANK_W,
  parameter int CNT_W = sbsl_pkg::CNT_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // command bus, active low strobes
  input wire logic clk_en_i,
  input wire logic chip_sel_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_en_n_i,
  input wire logic auto_precharge_addr_bit_i,
  input wire logic [BANK_W-1:0] bank_select_i,
  // decoded command
  output sbsl_pkg::sbsl_cmd_e cmd_o,
  output logic cmd_valid_o,
  // per bank state
  output logic [3*NUM_BANKS-1:0] bank_state_o,
  output logic [NUM_BANKS-1:0] bank_idle_o,
  // device-wide status
  output logic all_idle_o,
  output logic device_busy_o,
  output logic illegal_cmd_o,
  output logic [BANK_W-1:0] last_read_bank_o,
  output logic last_read_valid_o
);
  // ************************************************************
  // command decode
  // ************************************************************
  sbsl_pkg::sbsl_cmd_e cmd;
  logic [2:0] strobes;
  logic [NUM_BANKS-1:0] bank_hit;
  logic [NUM_BANKS-1:0] pre_hit;
  logic [NUM_BANKS-1:0] ok_bank;
  logic [NUM_BANKS-1:0] idle_vec;
  logic [NUM_BANKS-1:0] burst_vec;
  logic [NUM_BANKS-1:0] read_vec;
  logic [NUM_BANKS-1:0] force_idle;
  logic [NUM_BANKS-1:0] bst_hit;
  logic [CNT_W-1:0] dev_count;
  logic dev_busy;
  logic [BANK_W-1:0] last_rd_bank;
  logic last_rd_valid;
  logic legal;
  logic executable;
  logic dev_done;
  logic [1:0] dev_kind;
  logic [NUM_BANKS-1:0] act_v;
  logic [NUM_BANKS-1:0] rd_v;
  logic [NUM_BANKS-1:0] wr_v;
  logic [NUM_BANKS-1:0] pre_v;

  localparam logic [1:0] DEV_NONE = 2'h0;
  localparam logic [1:0] DEV_REFRESH = 2'h1;
  localparam logic [1:0] DEV_MODE = 2'h2;
  localparam logic [1:0] DEV_PREALL = 2'h3;

  assign strobes = {row_strobe_n_i, col_strobe_n_i, write_en_n_i};

  // strobe decode, chip select high is deselect
  always_comb begin
    cmd = sbsl_pkg::SBSL_CMD_DESELECT;
    if (chip_sel_n_i) begin
      cmd = sbsl_pkg::SBSL_CMD_DESELECT;
    end else if (strobes == 3'h7) begin
      cmd = sbsl_pkg::SBSL_CMD_NOP;
    end else if (strobes == 3'h3) begin
      cmd = sbsl_pkg::SBSL_CMD_ACTIVATE;
    end else if (strobes == 3'h5) begin
      cmd = sbsl_pkg::SBSL_CMD_READ;
    end else if (strobes == 3'h4) begin
      cmd = sbsl_pkg::SBSL_CMD_WRITE;
    end else if (strobes == 3'h2) begin
      cmd = sbsl_pkg::SBSL_CMD_PRECHARGE;
    end else if (strobes == 3'h6) begin
      cmd = sbsl_pkg::SBSL_CMD_BURST_TERM;
    end else if (strobes == 3'h1) begin
      cmd = sbsl_pkg::SBSL_CMD_REFRESH;
    end else begin
      cmd = sbsl_pkg::SBSL_CMD_LOAD_MODE;
    end
  end

  // ************************************************************
  // per bank legality and state
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      sbsl_pkg::sbsl_state_e st;
      assign bank_hit[gi] = (bank_select_i == BANK_W'(gi));
      assign pre_hit[gi] = auto_precharge_addr_bit_i | bank_hit[gi];
      assign idle_vec[gi] = (st == sbsl_pkg::SBSL_ST_IDLE);
      assign read_vec[gi] = (st == sbsl_pkg::SBSL_ST_READ) || (st == sbsl_pkg::SBSL_ST_READ_AP);
      assign burst_vec[gi] = read_vec[gi] || (st == sbsl_pkg::SBSL_ST_WRITE)
                             || (st == sbsl_pkg::SBSL_ST_WRITE_AP);
      assign bst_hit[gi] = (cmd == sbsl_pkg::SBSL_CMD_BURST_TERM) && last_rd_valid
                           && (last_rd_bank == BANK_W'(gi));
      assign bank_state_o[3*gi +: 3] = st;
      // legality of the current command against this bank's state
      always_comb begin
        ok_bank[gi] = 1'b1;
        case (cmd)
          sbsl_pkg::SBSL_CMD_ACTIVATE: begin
            ok_bank[gi] = !bank_hit[gi] || idle_vec[gi];
          end
          sbsl_pkg::SBSL_CMD_READ, sbsl_pkg::SBSL_CMD_WRITE: begin
            ok_bank[gi] = !bank_hit[gi] || (st == sbsl_pkg::SBSL_ST_ROW_ACTIVE)
                          || (st == sbsl_pkg::SBSL_ST_READ) || (st == sbsl_pkg::SBSL_ST_WRITE);
          end
          sbsl_pkg::SBSL_CMD_PRECHARGE: begin
            // precharging an idle bank is harmless
            ok_bank[gi] = !pre_hit[gi] || idle_vec[gi]
                          || (st == sbsl_pkg::SBSL_ST_ROW_ACTIVE)
                          || (st == sbsl_pkg::SBSL_ST_READ) || (st == sbsl_pkg::SBSL_ST_WRITE);
          end
          default: begin
            ok_bank[gi] = 1'b1;
          end
        endcase
      end
      assign act_v[gi] = executable && (cmd == sbsl_pkg::SBSL_CMD_ACTIVATE) && bank_hit[gi];
      assign rd_v[gi] = executable && (cmd == sbsl_pkg::SBSL_CMD_READ) && bank_hit[gi];
      assign wr_v[gi] = executable && (cmd == sbsl_pkg::SBSL_CMD_WRITE) && bank_hit[gi];
      // an idle bank under precharge all stays idle
      assign pre_v[gi] = executable && (cmd == sbsl_pkg::SBSL_CMD_PRECHARGE) && pre_hit[gi]
                         && !(auto_precharge_addr_bit_i && idle_vec[gi]);
      assign force_idle[gi] = dev_done;
      sbsl_bank #(
        .CNT_W(CNT_W)
      ) u_bank (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .act_i(act_v[gi]),
        .rd_i(rd_v[gi]),
        .wr_i(wr_v[gi]),
        .pre_i(pre_v[gi]),
        .auto_pre_i(auto_precharge_addr_bit_i),
        .burst_stop_i(executable && bst_hit[gi]),
        .force_idle_i(force_idle[gi]),
        .state_o(st),
        .count_o()
      );
    end
  endgenerate

  // ************************************************************
  // device-wide legality
  // ************************************************************
  // commands other than deselect/no operation that the state allows
  always_comb begin
    legal = &ok_bank;
    case (cmd)
      sbsl_pkg::SBSL_CMD_DESELECT, sbsl_pkg::SBSL_CMD_NOP: begin
        legal = 1'b1;
      end
      sbsl_pkg::SBSL_CMD_REFRESH, sbsl_pkg::SBSL_CMD_LOAD_MODE: begin
        legal = &idle_vec && !(|burst_vec);
      end
      sbsl_pkg::SBSL_CMD_BURST_TERM: begin
        legal = last_rd_valid;
      end
      sbsl_pkg::SBSL_CMD_WRITE: begin
        legal = (&ok_bank) && !(|read_vec);
      end
      default: begin
        legal = &ok_bank;
      end
    endcase
    if (dev_busy && cmd != sbsl_pkg::SBSL_CMD_DESELECT && cmd != sbsl_pkg::SBSL_CMD_NOP) begin
      legal = 1'b0;
    end
    // deselect and no operation stay legal with clock enable low
    if (!clk_en_i && cmd != sbsl_pkg::SBSL_CMD_DESELECT && cmd != sbsl_pkg::SBSL_CMD_NOP) begin
      legal = 1'b0;
    end
  end

  // only legal executable commands change state
  assign executable = legal && clk_en_i && (cmd != sbsl_pkg::SBSL_CMD_DESELECT)
                      && (cmd != sbsl_pkg::SBSL_CMD_NOP);

  // ************************************************************
  // device-wide timer for refresh, mode load and precharge all
  // ************************************************************
  assign dev_busy = (dev_kind != DEV_NONE);
  assign dev_done = dev_busy && (dev_count == '0);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dev_kind <= DEV_NONE;
      dev_count <= '0;
    end else if (executable && cmd == sbsl_pkg::SBSL_CMD_REFRESH) begin
      dev_kind <= DEV_REFRESH;
      dev_count <= CNT_W'(sbsl_pkg::REFRESH_CYC - 1);
    end else if (executable && cmd == sbsl_pkg::SBSL_CMD_LOAD_MODE) begin
      dev_kind <= DEV_MODE;
      dev_count <= CNT_W'(sbsl_pkg::MODE_LOAD_CYC - 1);
    end else if (executable && cmd == sbsl_pkg::SBSL_CMD_PRECHARGE && auto_precharge_addr_bit_i) begin
      dev_kind <= DEV_PREALL;
      dev_count <= CNT_W'(sbsl_pkg::PRECHARGE_CYC - 1);
    end else if (dev_done) begin
      dev_kind <= DEV_NONE; // all banks idle from here
    end else if (dev_busy) begin
      dev_count <= dev_count - CNT_W'(1);
    end
  end

  // ************************************************************
  // most recent read tracker
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_rd_bank <= '0;
      last_rd_valid <= 1'b0;
    end else if (executable && cmd == sbsl_pkg::SBSL_CMD_READ) begin
      last_rd_bank <= bank_select_i;
      last_rd_valid <= !auto_precharge_addr_bit_i; // terminate only without auto precharge
    end else if (executable && (cmd == sbsl_pkg::SBSL_CMD_BURST_TERM
                                || cmd == sbsl_pkg::SBSL_CMD_WRITE
                                || cmd == sbsl_pkg::SBSL_CMD_PRECHARGE)) begin
      last_rd_valid <= 1'b0;
    end else if (last_rd_valid && !read_vec[last_rd_bank]) begin
      last_rd_valid <= 1'b0; // burst ran out
    end
  end

  // ************************************************************
  // registered status outputs
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_o <= sbsl_pkg::SBSL_CMD_DESELECT;
      cmd_valid_o <= 1'b0;
      illegal_cmd_o <= 1'b0;
    end else begin
      cmd_o <= cmd;
      cmd_valid_o <= executable;
      illegal_cmd_o <= !legal;
    end
  end

  // state views
  assign bank_idle_o = idle_vec;
  assign all_idle_o = (&idle_vec) && !dev_busy;
  assign device_busy_o = dev_busy;
  assign last_read_bank_o = last_rd_bank;
  assign last_read_valid_o = last_rd_valid;
endmodule : sbsl_top

/* sbsl_top_assertions.sv */
// checker of command decode and bank state timing of the bank state logic
`timescale 1ns/1ps
module sbsl_top_checker #(
  parameter int NUM_BANKS = 4,
  parameter int BANK_W = 2,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // command pins
  input wire logic chip_sel_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_en_n_i,
  input wire logic auto_precharge_addr_bit_i,
  input wire logic [BANK_W-1:0] bank_select_i,
  // decoded command and states
  input wire logic [3:0] cmd_o,
  input wire logic cmd_valid_o,
  input wire logic [3*NUM_BANKS-1:0] bank_state_o,
  input wire logic all_idle_o,
  input wire logic device_busy_o,
  input wire logic illegal_cmd_o,
  input wire logic [BANK_W-1:0] last_read_bank_o,
  input wire logic last_read_valid_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ************************************************************
  // helpers
  // ************************************************************
  logic [BANK_W-1:0] b0, b1, b2, b3;
  logic [2:0] sel_st, st0, st1, st2, st3;
  logic is_nop, bank_cmd;
  // bank of the last sampled commands, oldest last
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {b0, b1, b2, b3} <= '0;
    end else begin
      {b0, b1, b2, b3} <= {bank_select_i, b0, b1, b2};
    end
  end
  // states of the addressed bank, now and delayed
  assign sel_st = bank_state_o[3*bank_select_i +: 3];
  assign st0 = bank_state_o[3*b0 +: 3];
  assign st1 = bank_state_o[3*b1 +: 3];
  assign st2 = bank_state_o[3*b2 +: 3];
  assign st3 = bank_state_o[3*b3 +: 3];
  assign is_nop = row_strobe_n_i && col_strobe_n_i && write_en_n_i;
  // activate, read, write or single precharge
  assign bank_cmd = !chip_sel_n_i && (row_strobe_n_i != col_strobe_n_i)
      && !(auto_precharge_addr_bit_i && !row_strobe_n_i && !write_en_n_i);
  // ************************************************************
  // assertions
  // ************************************************************
  chk_deselect_ignored: assert property (
    chip_sel_n_i |=> cmd_o == sbsl_pkg::SBSL_CMD_DESELECT && !cmd_valid_o && !illegal_cmd_o)
    else $error("deselect was acted on");
  chk_nop_ignored: assert property (
    !chip_sel_n_i && is_nop |=> cmd_o == sbsl_pkg::SBSL_CMD_NOP && !cmd_valid_o && !illegal_cmd_o)
    else $error("no operation was acted on");
  chk_activate_timing: assert property (
    cmd_valid_o && cmd_o == sbsl_pkg::SBSL_CMD_ACTIVATE |-> $past(sel_st) == sbsl_pkg::SBSL_ST_IDLE
    && st0 == sbsl_pkg::SBSL_ST_ACTIVATING ##1 st1 == sbsl_pkg::SBSL_ST_ROW_ACTIVE)
    else $error("activate timing wrong");
  chk_read_tracked: assert property (
    cmd_valid_o && cmd_o == sbsl_pkg::SBSL_CMD_READ && !$past(auto_precharge_addr_bit_i)
    |-> st0 == sbsl_pkg::SBSL_ST_READ && last_read_valid_o && last_read_bank_o == b0)
    else $error("read burst not tracked");
  chk_autopre_span: assert property (
    cmd_valid_o && cmd_o == sbsl_pkg::SBSL_CMD_READ && $past(auto_precharge_addr_bit_i)
    |-> st0 == sbsl_pkg::SBSL_ST_READ_AP ##1 st1 == sbsl_pkg::SBSL_ST_READ_AP
    ##1 st2 == sbsl_pkg::SBSL_ST_READ_AP ##1 st3 == sbsl_pkg::SBSL_ST_IDLE)
    else $error("auto precharge span wrong");
  chk_precharge_timing: assert property (
    cmd_valid_o && cmd_o == sbsl_pkg::SBSL_CMD_PRECHARGE && !$past(auto_precharge_addr_bit_i)
    && $past(sel_st) != sbsl_pkg::SBSL_ST_IDLE |-> st0 == sbsl_pkg::SBSL_ST_PRECHARGING
    ##1 st1 == sbsl_pkg::SBSL_ST_IDLE) else $error("precharge timing wrong");
  chk_device_timer: assert property (
    cmd_valid_o && (cmd_o inside {sbsl_pkg::SBSL_CMD_REFRESH, sbsl_pkg::SBSL_CMD_LOAD_MODE}
    || cmd_o == sbsl_pkg::SBSL_CMD_PRECHARGE && $past(auto_precharge_addr_bit_i))
    |-> device_busy_o ##1 !device_busy_o && all_idle_o) else $error("device timer wrong");
  chk_busy_bank_refuses: assert property (
    bank_cmd && sel_st inside {sbsl_pkg::SBSL_ST_ACTIVATING, sbsl_pkg::SBSL_ST_PRECHARGING,
    sbsl_pkg::SBSL_ST_READ_AP, sbsl_pkg::SBSL_ST_WRITE_AP} |=> illegal_cmd_o && !cmd_valid_o)
    else $error("busy bank took a command");
  // main scenarios
  cov_refresh: cover property (cmd_valid_o && cmd_o == sbsl_pkg::SBSL_CMD_REFRESH);
  cov_refused: cover property (illegal_cmd_o);
  cov_write_ap: cover property (st0 == sbsl_pkg::SBSL_ST_WRITE_AP);
endmodule : sbsl_top_checker

bind sbsl_top sbsl_top_checker #(.NUM_BANKS(NUM_BANKS), .BANK_W(BANK_W), .CNT_W(CNT_W))
  i_sbsl_top_checker (.sys_clk_i, .rst_n_i, .chip_sel_n_i, .row_strobe_n_i, .col_strobe_n_i,
  .write_en_n_i, .auto_precharge_addr_bit_i, .bank_select_i, .cmd_o, .cmd_valid_o,
  .bank_state_o, .all_idle_o, .device_busy_o, .illegal_cmd_o, .last_read_bank_o,
  .last_read_valid_o);

/* sbsl_ctrl_model.sv */
// memory controller model driving the command pins of the bank state logic
`timescale 1ns/1ps
module sbsl_ctrl_model (
  // clock and filler randomness
  input wire logic sys_clk_i,
  input wire logic [31:0] rnd_i,
  // command pins, select first
  output logic clk_en_o = 1'h1,
  output logic [3:0] pins_n_o = 4'hF,
  output logic ap_bit_o = 1'h0,
  output logic [1:0] bank_o = 2'h0
);
  // request posted by the bench
  logic req = 1'h0;
  logic cke = 1'h1;
  logic ap = 1'h0;
  logic [1:0] bank = 2'h0;
  sbsl_pkg::sbsl_cmd_e cmd = sbsl_pkg::SBSL_CMD_NOP;
  logic [3:0] code;
  // strobe pattern of each command
  always_comb begin
    case (cmd)
      sbsl_pkg::SBSL_CMD_ACTIVATE: code = 4'h3;
      sbsl_pkg::SBSL_CMD_READ: code = 4'h5;
      sbsl_pkg::SBSL_CMD_WRITE: code = 4'h4;
      sbsl_pkg::SBSL_CMD_PRECHARGE: code = 4'h2;
      sbsl_pkg::SBSL_CMD_BURST_TERM: code = 4'h6;
      sbsl_pkg::SBSL_CMD_REFRESH: code = 4'h1;
      sbsl_pkg::SBSL_CMD_LOAD_MODE: code = 4'h0;
      default: code = 4'h7;
    endcase
  end
  // one command per request, else deselect with junk strobes or no operation
  always @(negedge sys_clk_i) begin
    if (req) begin
      pins_n_o <= code;
      clk_en_o <= cke;
      ap_bit_o <= ap;
      bank_o <= bank;
      req = 1'h0;
      cke = 1'h1;
    end else begin
      pins_n_o <= rnd_i[0] ? {1'h1, rnd_i[3:1]} : 4'h7;
      clk_en_o <= 1'h1;
      ap_bit_o <= rnd_i[4];
      bank_o <= rnd_i[6:5];
    end
  end
endmodule : sbsl_ctrl_model

/* tb.sv */
// testbench of the bank state logic driven through a controller model
`timescale 1ns/1ps
module tb;
  // ************************************************************
  // signals
  // ************************************************************
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [31:0] seed = 32'hB1CF;
  logic clk_en, ap_bit, cmd_valid, all_idle, busy, illegal, lr_valid;
  logic [3:0] pins_n, bank_idle;
  logic [1:0] bank, lr_bank;
  logic [11:0] states;
  sbsl_pkg::sbsl_cmd_e cmd;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  typedef struct {logic [3:0] c; logic [2:0] f; logic [1:0] b; logic [2:0] s;} sbsl_note_s;
  sbsl_note_s notes[$];
  localparam sbsl_pkg::sbsl_cmd_e ACT = sbsl_pkg::SBSL_CMD_ACTIVATE, RD = sbsl_pkg::SBSL_CMD_READ,
    WR = sbsl_pkg::SBSL_CMD_WRITE, PRE = sbsl_pkg::SBSL_CMD_PRECHARGE,
    BT = sbsl_pkg::SBSL_CMD_BURST_TERM;
  localparam logic [2:0] IDL = sbsl_pkg::SBSL_ST_IDLE, ACV = sbsl_pkg::SBSL_ST_ACTIVATING,
    ROW = sbsl_pkg::SBSL_ST_ROW_ACTIVE, RST = sbsl_pkg::SBSL_ST_READ,
    WST = sbsl_pkg::SBSL_ST_WRITE, RAP = sbsl_pkg::SBSL_ST_READ_AP,
    WAP = sbsl_pkg::SBSL_ST_WRITE_AP, PCH = sbsl_pkg::SBSL_ST_PRECHARGING;
  // clock and random source
  always #50 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  always @(posedge sys_clk_i) seed <= xs(seed);
  // ************************************************************
  // instances
  // ************************************************************
  sbsl_ctrl_model i_sbsl_ctrl_model (.sys_clk_i(sys_clk_i), .rnd_i(seed), .clk_en_o(clk_en),
    .pins_n_o(pins_n), .ap_bit_o(ap_bit), .bank_o(bank));
  sbsl_top i_sbsl_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
    .chip_sel_n_i(pins_n[3]), .row_strobe_n_i(pins_n[2]), .col_strobe_n_i(pins_n[1]),
    .write_en_n_i(pins_n[0]), .auto_precharge_addr_bit_i(ap_bit), .bank_select_i(bank),
    .cmd_o(cmd), .cmd_valid_o(cmd_valid), .bank_state_o(states), .bank_idle_o(bank_idle),
    .all_idle_o(all_idle), .device_busy_o(busy), .illegal_cmd_o(illegal),
    .last_read_bank_o(lr_bank), .last_read_valid_o(lr_valid));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop;
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // post one command; f is auto precharge, refused, state checked
  task automatic issue(input sbsl_pkg::sbsl_cmd_e c, input logic [1:0] b, input logic [2:0] f,
      input logic [2:0] s);
    @(posedge sys_clk_i);
    i_sbsl_ctrl_model.cmd = c;
    i_sbsl_ctrl_model.bank = b;
    i_sbsl_ctrl_model.ap = f[2];
    i_sbsl_ctrl_model.req = 1'h1;
    notes.push_back('{c, f, b, s});
  endtask : issue
  // ************************************************************
  // result watcher and timeout
  // ************************************************************
  always @(negedge sys_clk_i) begin
    sbsl_note_s n;
    if (rst_n_i && (cmd_valid || illegal)) begin
      n = notes.pop_front();
      check("cmd", {8'h00, n.c}, {8'h00, cmd});
      check("flags", {10'h000, ~n.f[1], n.f[1]}, {10'h000, cmd_valid, illegal});
      if (n.f[0]) check("state", {9'h000, n.s}, {9'h000, states[3*n.b +: 3]});
    end
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 400) begin
      errors++;
      report_and_stop();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'h1;
    check("reset idle", 12'h01F, {7'h00, all_idle, bank_idle});
    issue(ACT, 2'h0, 3'h1, ACV);
    issue(ACT, 2'h1, 3'h1, ACV);
    issue(RD, 2'h0, 3'h1, RST);
    issue(WR, 2'h1, 3'h3, ROW);
    issue(BT, 2'h0, 3'h1, ROW);
    issue(WR, 2'h1, 3'h1, WST);
    issue(RD, 2'h1, 3'h5, RAP);
    issue(PRE, 2'h0, 3'h1, PCH);
    issue(ACT, 2'h1, 3'h3, RAP);
    repeat (3) @(posedge sys_clk_i);
    issue(sbsl_pkg::SBSL_CMD_REFRESH, seed[1:0], 3'h1, IDL);
    issue(ACT, 2'h2, 3'h3, IDL);
    issue(sbsl_pkg::SBSL_CMD_LOAD_MODE, 2'h0, 3'h1, IDL);
    issue(ACT, 2'h2, 3'h3, IDL);
    issue(ACT, 2'h2, 3'h1, ACV);
    issue(ACT, 2'h3, 3'h1, ACV);
    issue(WR, 2'h2, 3'h5, WAP);
    issue(RD, 2'h3, 3'h1, RST);
    repeat (5) @(posedge sys_clk_i);
    issue(PRE, 2'h0, 3'h4, PCH);
    issue(RD, 2'h3, 3'h3, IDL);
    issue(ACT, 2'h1, 3'h3, IDL);
    i_sbsl_ctrl_model.cke = 1'h0; // clock enable low for the activate just posted
    issue(RD, 2'h0, 3'h3, IDL);
    issue(BT, 2'h0, 3'h3, IDL);
    issue(PRE, 2'h2, 3'h0, IDL);
    repeat (4) @(posedge sys_clk_i);
    check("notes left", 12'h000, 12'(notes.size()));
    check("end idle", 12'h01F, {7'h00, all_idle, bank_idle});
    report_and_stop();
  end
endmodule : tb
